//--- pcw_pkg.sv
// What this block does
// - bit 7 of the low byte turns the internal calibration on when 1 and off when 0, off after reset.
// - bit 0 of the low byte keeps sensing shut down when 0, the reset state, and starts sensing when 1.
// - bit 14 selects 12-bit results when 0, the reset state, or 16-bit wide range results when 1.
// - bit 13 enables the sunlight protection interrupt when 1, disabled after reset.
// - bit 12 enables the adaptive persistence scheme when 1, disabled after reset.
// - bits 11:10 give the consecutive threshold crossings needed for an interrupt, codes 0 to 3 meaning 1 to 4.
// - interrupt decisions compare results with the 16-bit low threshold at code 0x03 and high threshold at 0x04.
package pcw_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_CONTROL = 8'h00;
  localparam logic [7:0] CMD_LOWER_THR = 8'h03;
  localparam logic [7:0] CMD_UPPER_THR = 8'h04;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CAL_BIT = 7;
  localparam int PWR_BIT = 0;
  localparam int WIDE_BIT = 14;
  localparam int SUN_BIT = 13;
  localparam int ADAPT_BIT = 12;
  localparam int CROSS_LSB = 10;
  localparam int MODE_LSB = 8;

  // ****************************************
  // reset values and result mask
  // ****************************************
  localparam logic [7:0] CONTROL_LOW_RESET = 8'h00;
  localparam logic [7:0] CONTROL_HIGH_RESET = 8'h00;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [15:0] NARROW_MASK = 16'h0fff;

  // ****************************************
  // interrupt mode codes
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LEVEL = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_EVENT = 2'h3;

  typedef struct packed {
    logic internal_calibration_enable;
    logic sensor_power_on;
    logic wide_range_output_select;
    logic sunlight_guard_irq_enable;
    logic adaptive_persistence_enable;
    logic [1:0] crossing_count_select;
    logic [1:0] irq_mode_select;
  } pcw_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic hi;
    logic [7:0] wdata;
  } pcw_req_t;

endpackage

//--- pcw_irq.sv
`timescale 1ns/1ps
module pcw_irq (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire pcw_pkg::pcw_cfg_t cfg,
  input wire logic [15:0] lower_thr,
  input wire logic [15:0] upper_thr,
  // measurement events
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic sunlight_event,
  input wire logic flag_clear,
  // decision
  output logic irq_assert
);

  // ****************************************
  // threshold compare
  // ****************************************
  logic [1:0] above_cnt_q, above_cnt_d, below_cnt_q, below_cnt_d;
  logic level_q, event_q;
  wire [15:0] result_w = cfg.wide_range_output_select ? result_data
                         : (result_data & pcw_pkg::NARROW_MASK);
  wire running = cfg.sensor_power_on;
  wire above = running && result_valid && (result_w > upper_thr);
  wire below = running && result_valid && (result_w < lower_thr);
  // at or past the count, so lowering the count in mid-streak still fires
  wire hit_hi = above && (above_cnt_q >= cfg.crossing_count_select);
  wire hit_lo = below && (below_cnt_q >= cfg.crossing_count_select);
  wire sun_hit = running && sunlight_event && cfg.sunlight_guard_irq_enable;
  wire mode_level = cfg.irq_mode_select == pcw_pkg::MODE_LEVEL;
  wire mode_event = cfg.irq_mode_select == pcw_pkg::MODE_EVENT;

  // saturate at the needed count so a long run keeps firing each sample
  always_comb begin
    above_cnt_d = above_cnt_q;
    below_cnt_d = below_cnt_q;
    if (!running) begin
      above_cnt_d = 2'h0;
      below_cnt_d = 2'h0;
    end else if (result_valid) begin
      above_cnt_d = !above ? 2'h0 : (hit_hi ? above_cnt_q : above_cnt_q + 2'h1);
      below_cnt_d = !below ? 2'h0 : (hit_lo ? below_cnt_q : below_cnt_q + 2'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      above_cnt_q <= 2'h0;
      below_cnt_q <= 2'h0;
      level_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      above_cnt_q <= above_cnt_d;
      below_cnt_q <= below_cnt_d;
      if (hit_hi) begin
        level_q <= 1'b1;
      end else if (hit_lo || !running) begin
        level_q <= 1'b0;
      end
      // a new event beats a clear in the same cycle
      if ((mode_event && (hit_hi || hit_lo)) || sun_hit) begin
        event_q <= 1'b1;
      end else if (flag_clear) begin
        event_q <= 1'b0;
      end
    end
  end

  // reserved mode 10 falls through as off
  assign irq_assert = (mode_level && level_q) || ((mode_event || cfg.sunlight_guard_irq_enable) && event_q);

endmodule // pcw_irq

//--- pcw_top.sv
`timescale 1ns/1ps
module pcw_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte register port from the serial engine
  input wire pcw_pkg::pcw_req_t req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // measurement side
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic sunlight_event,
  input wire logic flag_clear,
  // configuration to the sensing core
  output pcw_pkg::pcw_cfg_t cfg_out,
  // open-drain interrupt pin
  output logic int_pin_o,
  output logic int_pin_oe_n
);

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] ctrl_lo_q, ctrl_hi_q;
  logic [15:0] lower_thr_q, upper_thr_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic oe_n_q;
  pcw_pkg::pcw_cfg_t cfg_q;
  logic irq_assert;

  wire sel_ctrl = req.cmd == pcw_pkg::CMD_CONTROL;
  wire sel_lower = req.cmd == pcw_pkg::CMD_LOWER_THR;
  wire sel_upper = req.cmd == pcw_pkg::CMD_UPPER_THR;
  wire wr_ctrl_lo = req.wr && sel_ctrl && !req.hi;
  wire wr_ctrl_hi = req.wr && sel_ctrl && req.hi;
  // reserved bits are stored as zero so a careless write cannot upset the core
  wire [7:0] lo_wmask = 8'h81;
  wire [7:0] hi_wmask = 8'h7f;

  // ****************************************
  // read decode
  // ****************************************
  wire [7:0] rd_ctrl = req.hi ? ctrl_hi_q : ctrl_lo_q;
  wire [7:0] rd_lower = req.hi ? lower_thr_q[15:8] : lower_thr_q[7:0];
  wire [7:0] rd_upper = req.hi ? upper_thr_q[15:8] : upper_thr_q[7:0];
  wire [7:0] rd_mux = sel_ctrl ? rd_ctrl : sel_lower ? rd_lower : sel_upper ? rd_upper : pcw_pkg::UNMAPPED_READ;

  // ****************************************
  // field split
  // ****************************************
  wire [15:0] ctrl_w = {ctrl_hi_q, ctrl_lo_q};
  pcw_pkg::pcw_cfg_t cfg_w;
  assign cfg_w.internal_calibration_enable = ctrl_w[pcw_pkg::CAL_BIT];
  assign cfg_w.sensor_power_on = ctrl_w[pcw_pkg::PWR_BIT];
  assign cfg_w.wide_range_output_select = ctrl_w[pcw_pkg::WIDE_BIT];
  assign cfg_w.sunlight_guard_irq_enable = ctrl_w[pcw_pkg::SUN_BIT];
  assign cfg_w.adaptive_persistence_enable = ctrl_w[pcw_pkg::ADAPT_BIT];
  assign cfg_w.crossing_count_select = ctrl_w[pcw_pkg::CROSS_LSB +: 2];
  assign cfg_w.irq_mode_select = ctrl_w[pcw_pkg::MODE_LSB +: 2];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_lo_q <= pcw_pkg::CONTROL_LOW_RESET;
      ctrl_hi_q <= pcw_pkg::CONTROL_HIGH_RESET;
    end else begin
      if (wr_ctrl_lo) begin
        ctrl_lo_q <= req.wdata & lo_wmask;
      end
      if (wr_ctrl_hi) begin
        ctrl_hi_q <= req.wdata & hi_wmask;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lower_thr_q <= pcw_pkg::THR_RESET;
      upper_thr_q <= pcw_pkg::THR_RESET;
    end else if (req.wr) begin
      if (sel_lower && !req.hi) lower_thr_q[7:0] <= req.wdata;
      if (sel_lower && req.hi) lower_thr_q[15:8] <= req.wdata;
      if (sel_upper && !req.hi) upper_thr_q[7:0] <= req.wdata;
      if (sel_upper && req.hi) upper_thr_q[15:8] <= req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= pcw_pkg::UNMAPPED_READ;
      rvalid_q <= 1'b0;
      cfg_q <= '0;
      oe_n_q <= 1'b1;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) rdata_q <= rd_mux;
      cfg_q <= cfg_w;
      oe_n_q <= !irq_assert; // pin pulled low only while asserted
    end
  end

  // ****************************************
  // interrupt evaluation
  // ****************************************
  pcw_irq u_irq (
    .clk(clk),
    .rst(rst),
    .cfg(cfg_w),
    .lower_thr(lower_thr_q),
    .upper_thr(upper_thr_q),
    .result_valid(result_valid),
    .result_data(result_data),
    .sunlight_event(sunlight_event),
    .flag_clear(flag_clear),
    .irq_assert(irq_assert)
  );

  // open drain: the driven level is always low, only the enable moves
  always_ff @(posedge clk) begin
    int_pin_o <= 1'b0;
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign cfg_out = cfg_q;
  assign int_pin_oe_n = oe_n_q;

endmodule // pcw_top

//--- pcw_monitor.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module pcw_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire pcw_pkg::pcw_req_t req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire pcw_pkg::pcw_cfg_t cfg_out,
  input wire logic int_pin_o,
  input wire logic int_pin_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wlo = req.wr && req.cmd == 8'h00 && !req.hi;
  wire logic whi = req.wr && req.cmd == 8'h00 && req.hi;
  wire logic wthr = req.wr && !req.rd && (req.cmd == 8'h03 || req.cmd == 8'h04);
  AST_CAL: assert property (wlo |-> ##2 cfg_out[8] == $past(req.wdata[7], 2))
    else $error("calibration enable wrong");
  AST_PWR: assert property (wlo |-> ##2 cfg_out[7] == $past(req.wdata[0], 2))
    else $error("power bit wrong");
  AST_WIDE: assert property (whi |-> ##2 cfg_out[6] == $past(req.wdata[6], 2))
    else $error("width select wrong");
  AST_HI: assert property (whi |-> ##2 cfg_out[5:0] == $past(req.wdata[5:0], 2))
    else $error("high fields wrong");
  AST_RSV: assert property (req.rd && req.cmd == 8'h00 |=> (reg_rdata & ($past(req.hi) ? 8'h80 : 8'h7e)) == 8'h00)
    else $error("reserved bits not zero");
  AST_THR: assert property (wthr ##1 (req.rd && !req.wr && $stable(req.cmd) && $stable(req.hi))
    |=> reg_rvalid && reg_rdata == $past(req.wdata, 2))
    else $error("threshold readback wrong");
  AST_OD: assert property (!int_pin_o)
    else $error("pin driven high");
  AST_MODE: assert property ($fell(int_pin_oe_n) && !cfg_out[5] |-> cfg_out[1:0] inside {2'h1, 2'h3})
    else $error("irq in off mode");
endmodule // pcw_monitor
bind pcw_top pcw_monitor i_mon (.clk(clk), .rst(rst), .req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .cfg_out(cfg_out), .int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n));

//--- pcw_host.sv
`timescale 1ns/1ps
// ****
// host byte port model
// ****
module pcw_host (
  // clock
  input wire logic clk,
  // byte port
  output pcw_pkg::pcw_req_t req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] c, input logic h, input logic [7:0] v);
    req.cmd = c;
    req.hi = h;
    req.wdata = c != 8'h00 ? v : v & (h ? 8'h7f : 8'h81);
    req.wr = 1'b1;
    @(posedge clk);
    #1 req.wr = 1'b0;
    req.wdata = ~req.wdata;
  endtask
  task automatic rd(input logic [7:0] c, input logic h, output logic [7:0] v);
    req.cmd = c;
    req.hi = h;
    req.rd = 1'b1;
    @(posedge clk);
    #1 req.rd = 1'b0;
    // answer stands for the whole cycle after the taken edge
    v = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule // pcw_host

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk, rst, rv, se, fc, rvalid, odo, oen;
  logic [15:0] rdat;
  logic [7:0] d, rdata;
  pcw_pkg::pcw_req_t req;
  pcw_pkg::pcw_cfg_t cfg;
  int n_fail = 0;
  int n_checks = 0;
  pcw_host i_host (.clk(clk), .req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  pcw_top i_dut (.clk(clk), .rst(rst), .req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .result_valid(rv),
    .result_data(rdat), .sunlight_event(se), .flag_clear(fc), .cfg_out(cfg), .int_pin_o(odo), .int_pin_oe_n(oen));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic res(input logic [15:0] v);
    rdat = v;
    rv = 1'b1;
    cyc(1);
    rv = 1'b0;
    rdat = ~v;
  endtask
  task automatic wrrd(input logic [7:0] c, input logic h, input logic [7:0] v, input logic [7:0] e);
    i_host.wr(c, h, v);
    i_host.rd(c, h, d);
    `CHK("readback", e, d)
  endtask
  task automatic t_reset;
    logic [7:0] cl [4] = '{8'h00, 8'h03, 8'h04, 8'h05};
    for (int i = 0; i < 8; i++) begin
      i_host.rd(cl[i/2], i[0], d);
      `CHK("rst_rd", 8'h00, d)
      cyc(1);
    end
    `CHK("rst_cfg", 9'h000, cfg)
    `CHK("rst_oen", 1'b1, oen)
  endtask
  task automatic t_cfg;
    logic [7:0] lv [4] = '{8'h81, 8'h01, 8'h80, 8'hff};
    logic [7:0] hv [4] = '{8'h7f, 8'h2a, 8'h55, 8'hc0};
    for (int i = 0; i < 4; i++) begin
      wrrd(8'h00, 1'b0, lv[i], lv[i] & 8'h81);
      wrrd(8'h00, 1'b1, hv[i], hv[i] & 8'h7f);
      `CHK("cfg", {lv[i][7], lv[i][0], hv[i][6:0]}, cfg)
    end
    wrrd(8'h03, 1'b0, 8'h10, 8'h10);
    wrrd(8'h03, 1'b1, 8'h00, 8'h00);
    wrrd(8'h04, 1'b0, 8'h00, 8'h00);
    wrrd(8'h04, 1'b1, 8'h01, 8'h01);
  endtask
  task automatic t_irq;
    i_host.wr(8'h00, 1'b0, 8'h01);
    cyc(1);
    i_host.wr(8'h00, 1'b1, 8'h07);
    // masked result breaks the streak in narrow mode
    res(16'h0200);
    res(16'hf050);
    res(16'h0200);
    cyc(2);
    `CHK("narrow", 1'b1, oen)
    res(16'h0200);
    `CHK("early", 1'b1, oen)
    cyc(1);
    `CHK("fire", 1'b0, oen)
    res(16'h0005);
    cyc(3);
    `CHK("event_held", 1'b0, oen)
    fc = 1'b1;
    cyc(1);
    fc = 1'b0;
    cyc(1);
    `CHK("cleared", 1'b1, oen)
    // power off drops the level left over from the event run
    i_host.wr(8'h00, 1'b0, 8'h00);
    cyc(1);
    i_host.wr(8'h00, 1'b0, 8'h01);
    cyc(1);
    i_host.wr(8'h00, 1'b1, 8'h01);
    cyc(1);
    `CHK("level_idle", 1'b1, oen)
    res(16'h0200);
    res(16'h0050);
    cyc(1);
    `CHK("level_hi", 1'b0, oen)
    res(16'h0005);
    cyc(1);
    `CHK("level_lo", 1'b1, oen)
    i_host.wr(8'h00, 1'b1, 8'h02);
    res(16'h0200);
    cyc(3);
    `CHK("mode_rsv", 1'b1, oen)
    i_host.wr(8'h00, 1'b1, 8'h20);
    se = 1'b1;
    cyc(1);
    se = 1'b0;
    cyc(1);
    `CHK("sun", 1'b0, oen)
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {rv, se, fc} = 3'h0;
    rdat = 16'h0000;
    cyc(2);
    rst = 1'b0;
    cyc(1);
    t_reset;
    t_cfg;
    t_irq;
    results;
  end
  initial begin
    #20000;
    n_fail++;
    results;
  end
endmodule // tb_top
